// ===== rtl/timer8_compare_waveform_unit.sv
/*
  8-bit timer with one compare unit and its waveform output: normal,
  clear-on-match and fast pwm modes, overflow and compare flags, and the
  override of a general port pin by the waveform output bit.
  assumes a classic wishbone master, a prescaled timer tick that is one
  clk_i cycle wide and synchronous, and an external pad that drives the pin
  when pin_oe_n_o is low.

*/
module timer8_compare_waveform_unit (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        timer_tick_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic             wb_ack_o,
  output logic [31:0]      wb_dat_o,
  output logic             pin_o,
  output logic             pin_oe_n_o
);

  logic [1:0] waveform_mode_select_reg;
  logic [1:0] compare_output_mode_reg;
  logic [7:0] count_value_reg;
  logic [7:0] count_value_next;
  logic [7:0] compare_buffer_reg;
  logic [7:0] compare_value_reg;
  logic       overflow_flag_reg;
  logic       compare_flag_reg;
  logic       waveform_output_bit_reg;
  logic       waveform_output_bit_next;
  logic       match_block_reg;
  logic       waveform_pin_direction_reg;
  logic       port_data_reg;
  logic       ack_reg;
  logic [31:0] rdata_reg;
  logic       pin_reg;
  logic       pin_oe_n_reg;

  logic       bus_req;
  logic       bus_wr;
  logic       ctrl_wr;
  logic       count_wr;
  logic       compare_wr;
  logic       flags_wr;
  logic       pin_wr;
  logic       is_pwm;
  logic       match;
  logic       at_max;
  logic       period_end;
  logic       force_now;
  logic [1:0] force_com;

  // a write takes effect on the edge where the master sees ack high
  assign bus_req    = wb_cyc_i && wb_stb_i;
  assign bus_wr     = bus_req && ack_reg && wb_we_i && wb_sel_i[0];
  assign ctrl_wr    = bus_wr && (wb_adr_i == timer8_pkg::CTRL_OFS);
  assign count_wr   = bus_wr && (wb_adr_i == timer8_pkg::COUNT_OFS);
  assign compare_wr = bus_wr && (wb_adr_i == timer8_pkg::COMPARE_OFS);
  assign flags_wr   = bus_wr && (wb_adr_i == timer8_pkg::FLAGS_OFS);
  assign pin_wr     = bus_wr && (wb_adr_i == timer8_pkg::PIN_OFS);

  assign is_pwm = (waveform_mode_select_reg == timer8_pkg::MODE_FAST_PWM) ||
                  (waveform_mode_select_reg == timer8_pkg::MODE_PHASE);
  assign match  = (count_value_reg == compare_value_reg) && !match_block_reg;
  assign at_max = (count_value_reg == timer8_pkg::COUNT_MAX);
  // the tick that takes the counter off max; a counter write overrides it
  assign period_end = timer_tick_i && at_max && !count_wr;

  // force uses the output mode written together with the strobe
  assign force_com = wb_dat_i[timer8_pkg::COM_MSB:timer8_pkg::COM_LSB];
  assign force_now = ctrl_wr && wb_dat_i[timer8_pkg::FORCE_BIT] && !is_pwm;

  // bus answer: ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req && !ack_reg;
    end
  end

  // read data is latched as the request arrives; unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= timer8_pkg::WORD_ZERO;
    end else if (bus_req && !ack_reg) begin
      rdata_reg <= timer8_pkg::WORD_ZERO;
      case (wb_adr_i)
        timer8_pkg::CTRL_OFS: begin
          rdata_reg[timer8_pkg::MODE_MSB:timer8_pkg::MODE_LSB] <= waveform_mode_select_reg;
          rdata_reg[timer8_pkg::COM_MSB:timer8_pkg::COM_LSB]   <= compare_output_mode_reg;
        end
        timer8_pkg::COUNT_OFS: begin
          rdata_reg[7:0] <= count_value_reg;
        end
        timer8_pkg::COMPARE_OFS: begin
          rdata_reg[7:0] <= compare_buffer_reg;
        end
        timer8_pkg::FLAGS_OFS: begin
          rdata_reg[timer8_pkg::OVF_BIT] <= overflow_flag_reg;
          rdata_reg[timer8_pkg::CMP_BIT] <= compare_flag_reg;
        end
        timer8_pkg::PIN_OFS: begin
          rdata_reg[timer8_pkg::DIR_BIT]  <= waveform_pin_direction_reg;
          rdata_reg[timer8_pkg::PORT_BIT] <= port_data_reg;
          rdata_reg[timer8_pkg::WOB_BIT]  <= waveform_output_bit_reg;
        end
        default: begin
          rdata_reg <= timer8_pkg::WORD_ZERO;
        end
      endcase
    end
  end

  // mode fields; a changed output mode acts from the next clk_i, at the pin mux as well as at a match
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      waveform_mode_select_reg <= timer8_pkg::FIELD_RESET;
      compare_output_mode_reg  <= timer8_pkg::FIELD_RESET;
    end else if (ctrl_wr) begin
      waveform_mode_select_reg <= wb_dat_i[timer8_pkg::MODE_MSB:timer8_pkg::MODE_LSB];
      compare_output_mode_reg  <= wb_dat_i[timer8_pkg::COM_MSB:timer8_pkg::COM_LSB];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      waveform_pin_direction_reg <= 1'b0;
      port_data_reg              <= 1'b0;
    end else if (pin_wr) begin
      waveform_pin_direction_reg <= wb_dat_i[timer8_pkg::DIR_BIT];
      port_data_reg              <= wb_dat_i[timer8_pkg::PORT_BIT];
    end
  end

  // counter: a bus write beats clear and count; the sequence depends on the mode and, in clear-on-match, on the compare value
  always_comb begin
    count_value_next = count_value_reg;
    if (count_wr) begin
      count_value_next = wb_dat_i[7:0];
    end else if (timer_tick_i) begin
      case (waveform_mode_select_reg)
        timer8_pkg::MODE_CLEAR_ON: begin
          count_value_next = match ? timer8_pkg::COUNT_BOTTOM : 8'(count_value_reg + 8'h01);
        end
        default: begin
          count_value_next = 8'(count_value_reg + 8'h01);
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_value_reg <= timer8_pkg::BYTE_RESET;
    end else begin
      count_value_reg <= count_value_next;
    end
  end

  // the block holds from a counter write until the next tick has passed
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      match_block_reg <= 1'b0;
    end else if (count_wr) begin
      match_block_reg <= 1'b1;
    end else if (timer_tick_i) begin
      match_block_reg <= 1'b0;
    end
  end

  // compare value: direct in non-pwm modes, buffered to the period end in pwm
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      compare_buffer_reg <= timer8_pkg::BYTE_RESET;
      compare_value_reg  <= timer8_pkg::BYTE_RESET;
    end else begin
      if (compare_wr) begin
        compare_buffer_reg <= wb_dat_i[7:0];
      end
      if (!is_pwm && compare_wr) begin
        compare_value_reg <= wb_dat_i[7:0];
      end else if (is_pwm && period_end) begin
        compare_value_reg <= compare_buffer_reg;
      end
    end
  end

  // flags: hardware only sets, software writes one to clear, set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      overflow_flag_reg <= 1'b0;
    end else if (period_end) begin
      overflow_flag_reg <= 1'b1;
    end else if (flags_wr && wb_dat_i[timer8_pkg::OVF_BIT]) begin
      overflow_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      compare_flag_reg <= 1'b0;
    end else if (timer_tick_i && match) begin
      compare_flag_reg <= 1'b1;
    end else if (flags_wr && wb_dat_i[timer8_pkg::CMP_BIT]) begin
      compare_flag_reg <= 1'b0;
    end
  end

  // waveform bit; in fast pwm the bottom action beats the match action,
  // which is what gives the constant level when the compare value is max
  always_comb begin
    waveform_output_bit_next = waveform_output_bit_reg;
    if (force_now) begin
      case (force_com)
        timer8_pkg::COM_TOGGLE: waveform_output_bit_next = !waveform_output_bit_reg;
        timer8_pkg::COM_CLEAR:  waveform_output_bit_next = 1'b0;
        timer8_pkg::COM_SET:    waveform_output_bit_next = 1'b1;
        default:                waveform_output_bit_next = waveform_output_bit_reg;
      endcase
    end else if (timer_tick_i) begin
      case (waveform_mode_select_reg)
        timer8_pkg::MODE_NORMAL, timer8_pkg::MODE_CLEAR_ON: begin
          if (match) begin
            case (compare_output_mode_reg)
              timer8_pkg::COM_TOGGLE: waveform_output_bit_next = !waveform_output_bit_reg;
              timer8_pkg::COM_CLEAR:  waveform_output_bit_next = 1'b0;
              timer8_pkg::COM_SET:    waveform_output_bit_next = 1'b1;
              default:                waveform_output_bit_next = waveform_output_bit_reg;
            endcase
          end
        end
        timer8_pkg::MODE_FAST_PWM: begin
          case (compare_output_mode_reg)
            timer8_pkg::COM_TOGGLE: begin
              if (match) begin
                waveform_output_bit_next = !waveform_output_bit_reg;
              end
            end
            timer8_pkg::COM_CLEAR: begin
              if (period_end) begin
                waveform_output_bit_next = 1'b1;
              end else if (match) begin
                waveform_output_bit_next = 1'b0;
              end
            end
            timer8_pkg::COM_SET: begin
              if (period_end) begin
                waveform_output_bit_next = 1'b0;
              end else if (match) begin
                waveform_output_bit_next = 1'b1;
              end
            end
            default: begin
              waveform_output_bit_next = waveform_output_bit_reg;
            end
          endcase
        end
        default: begin
          // phase correct waveform is not built; the bit holds
          waveform_output_bit_next = waveform_output_bit_reg;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      waveform_output_bit_reg <= 1'b0;
    end else begin
      waveform_output_bit_reg <= waveform_output_bit_next;
    end
  end

  // pin mux registered so outputs come from flops; one clk_i of lag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_reg      <= 1'b0;
      pin_oe_n_reg <= 1'b1;
    end else begin
      pin_reg      <= (compare_output_mode_reg != timer8_pkg::COM_OFF) ?
                      waveform_output_bit_reg : port_data_reg;
      pin_oe_n_reg <= !waveform_pin_direction_reg;
    end
  end

  assign wb_ack_o   = ack_reg;
  assign wb_dat_o   = rdata_reg;
  assign pin_o      = pin_reg;
  assign pin_oe_n_o = pin_oe_n_reg;

  sequence s_fast_tick;
    timer_tick_i && !count_wr && !force_now && (waveform_mode_select_reg == timer8_pkg::MODE_FAST_PWM);
  endsequence

  sequence s_count_write;
    count_wr && !compare_flag_reg && !(timer_tick_i && match);
  endsequence

  a_reset_clears_bit: assert property (@(posedge clk_i)
    rst_i |=> !waveform_output_bit_reg)
    else $error("waveform bit not zero after reset");

  a_pin_override: assert property (@(posedge clk_i) disable iff (rst_i)
    (compare_output_mode_reg != timer8_pkg::COM_OFF) |=> pin_o == $past(waveform_output_bit_reg))
    else $error("pin does not follow waveform bit under override");

  a_com_zero_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    timer_tick_i && !force_now && (compare_output_mode_reg == timer8_pkg::COM_OFF) |=> $stable(waveform_output_bit_reg))
    else $error("waveform bit moved with output mode zero");

  a_force_no_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    force_now && !(timer_tick_i && match) && !compare_flag_reg && !count_wr && !timer_tick_i
    |=> !compare_flag_reg && $stable(count_value_reg))
    else $error("force changed flag or counter");

  a_force_toggle: assert property (@(posedge clk_i) disable iff (rst_i)
    force_now && (force_com == timer8_pkg::COM_TOGGLE) |=> waveform_output_bit_reg != $past(waveform_output_bit_reg))
    else $error("force toggle did not act at once");

  a_normal_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
    timer_tick_i && at_max && !count_wr && (waveform_mode_select_reg == timer8_pkg::MODE_NORMAL)
    |=> (count_value_reg == timer8_pkg::COUNT_BOTTOM) && overflow_flag_reg)
    else $error("normal mode wrap or overflow wrong");

  a_clear_on_match: assert property (@(posedge clk_i) disable iff (rst_i)
    timer_tick_i && match && !count_wr && (waveform_mode_select_reg == timer8_pkg::MODE_CLEAR_ON)
    |=> count_value_reg == timer8_pkg::COUNT_BOTTOM)
    else $error("counter not cleared on match");

  a_match_toggle: assert property (@(posedge clk_i) disable iff (rst_i)
    timer_tick_i && match && !force_now && (waveform_mode_select_reg == timer8_pkg::MODE_CLEAR_ON) &&
    (compare_output_mode_reg == timer8_pkg::COM_TOGGLE) |=> $changed(waveform_output_bit_reg))
    else $error("no toggle on match");

  a_fast_bottom: assert property (@(posedge clk_i) disable iff (rst_i)
    s_fast_tick and (at_max && compare_output_mode_reg == timer8_pkg::COM_CLEAR)
    |=> waveform_output_bit_reg && (count_value_reg == timer8_pkg::COUNT_BOTTOM))
    else $error("non-inverting pwm not set at bottom");

  a_fast_match: assert property (@(posedge clk_i) disable iff (rst_i)
    s_fast_tick and (match && !at_max && compare_output_mode_reg == timer8_pkg::COM_SET)
    |=> waveform_output_bit_reg)
    else $error("inverting pwm not set on match");

  a_buffer_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    is_pwm && !period_end ##1 is_pwm |-> $stable(compare_value_reg))
    else $error("active compare changed mid period");

  a_compare_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    timer_tick_i && match |=> compare_flag_reg)
    else $error("compare flag not set after match");

  a_write_blocks: assert property (@(posedge clk_i) disable iff (rst_i)
    s_count_write ##1 (timer_tick_i && !count_wr && !flags_wr) |=> !compare_flag_reg)
    else $error("match not blocked after counter write");

  a_tick_only: assert property (@(posedge clk_i) disable iff (rst_i)
    !timer_tick_i && !count_wr |=> $stable(count_value_reg))
    else $error("counter moved without tick");

endmodule : timer8_compare_waveform_unit

// ===== rtl/timer8_pkg.sv
/*
  constants for the 8-bit timer compare and waveform unit: register offsets,
  field positions, mode and polarity codes, reset values.
  assumes a classic wishbone bus with 32-bit data and byte addresses.
*/
package timer8_pkg;

  // register byte offsets, one aligned word each
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] COUNT_OFS   = 8'h04;
  localparam logic [7:0] COMPARE_OFS = 8'h08;
  localparam logic [7:0] FLAGS_OFS   = 8'h0c;
  localparam logic [7:0] PIN_OFS     = 8'h10;

  // control word fields
  localparam int MODE_LSB  = 0;
  localparam int MODE_MSB  = 1;
  localparam int COM_LSB   = 4;
  localparam int COM_MSB   = 5;
  localparam int FORCE_BIT = 7;

  // flag word fields, write one to clear
  localparam int OVF_BIT = 0;
  localparam int CMP_BIT = 1;

  // pin word fields
  localparam int DIR_BIT  = 0;
  localparam int PORT_BIT = 1;
  localparam int WOB_BIT  = 2;

  // waveform mode codes
  localparam logic [1:0] MODE_NORMAL   = 2'h0;
  localparam logic [1:0] MODE_PHASE    = 2'h1;
  localparam logic [1:0] MODE_CLEAR_ON = 2'h2;
  localparam logic [1:0] MODE_FAST_PWM = 2'h3;

  // compare output mode codes
  localparam logic [1:0] COM_OFF    = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR  = 2'h2;
  localparam logic [1:0] COM_SET    = 2'h3;

  // counter extremes and reset values
  localparam logic [7:0]  COUNT_MAX    = 8'hff;
  localparam logic [7:0]  COUNT_BOTTOM = 8'h00;
  localparam logic [7:0]  BYTE_RESET   = 8'h00;
  localparam logic [1:0]  FIELD_RESET  = 2'h0;
  localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;

endpackage : timer8_pkg

// ===== sim/pin_pad_model.sv
/*
  pad model for the waveform pin of the timer unit.
  assumes the unit drives the pad while oe_n_i is low.
*/
module pin_pad_model (
  input  wire logic clk_i,
  input  wire logic pin_i,
  input  wire logic oe_n_i,
  output logic      pad_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_reg = 1'b0;
  // an undriven pad shows the inverse of the last level, so a stale copy cannot pass
  always_ff @(posedge clk_i) if (!oe_n_i) last_reg <= pin_i;
  assign pad_o = oe_n_i ? ~last_reg : pin_i;
endmodule : pin_pad_model

// ===== sim/tb_timer8_compare_waveform_unit.sv
/*
  self-checking bench for the 8-bit timer compare and waveform unit.
  assumes one-cycle wishbone answers and a pad model on the waveform pin.
*/
module tb_timer8_compare_waveform_unit;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i       = 1'b0;
  logic        rst_i       = 1'b1;
  logic        tick        = 1'b0;
  logic        req         = 1'b0;
  logic        we          = 1'b0;
  logic [7:0]  adr         = 8'h00;
  logic [31:0] wdat        = 32'h00000000;
  logic [3:0]  sel         = 4'h0;
  logic [3:0]  lanes       = 4'hf;
  logic        ack;
  logic [31:0] rdat;
  logic [31:0] got;
  logic        pin;
  logic        oe_n;
  logic        pad;
  int          mismatches  = 0;
  int          comparisons = 0;
  int          c;
  int          c2;
  int          p;
  int          hi;
  logic [1:0]  tcom [6]    = '{2'h2, 2'h3, 2'h2, 2'h3, 2'h2, 2'h1};
  int          tcv [6];

  timer8_compare_waveform_unit timer8_compare_waveform_unit_inst (
    .clk_i(clk_i), .rst_i(rst_i), .timer_tick_i(tick),
    .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(rdat),
    .pin_o(pin), .pin_oe_n_o(oe_n));

  pin_pad_model pin_pad_model_inst (.clk_i(clk_i), .pin_i(pin), .oe_n_i(oe_n), .pad_o(pad));

  initial forever #2 clk_i = ~clk_i;

  task automatic end_sim;
    if (mismatches == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic check_val(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %0t value %h expected %h", $time, g, e);
    end
  endtask : check_val

  task automatic check_num(input int g, input int e);
    comparisons++;
    if (g != e) begin
      mismatches++;
      $display("CHECK FAILED %0t high cycles %0d expected %0d", $time, g, e);
    end
  endtask : check_num

  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    req  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= {24'h000000, d};
    sel  <= lanes;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 16);
    if (ack !== 1'b1) begin
      mismatches++;
      $display("CHECK FAILED %0t no bus answer", $time);
    end
    got = rdat;
    req <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb(1'b1, a, d);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    check_val(got, {24'h000000, e});
  endtask : rd_chk

  // the bus stays idle while ticking, so every count below is exact
  task automatic tick_n(input int n);
    @(posedge clk_i);
    tick <= 1'b1;
    repeat (n - 1) @(posedge clk_i);
    @(posedge clk_i);
    tick <= 1'b0;
  endtask : tick_n

  function automatic logic [7:0] ctrl(input logic [1:0] m, input logic [1:0] cm, input logic f);
    return 8'(m) << timer8_pkg::MODE_LSB | 8'(cm) << timer8_pkg::COM_LSB | 8'(f) << timer8_pkg::FORCE_BIT;
  endfunction : ctrl

  function automatic logic [7:0] pinw(input logic w);
    return {5'h00, w, p[0], 1'b1};
  endfunction : pinw

  // high cycles of the pad over two full periods
  function automatic int exp_high(input logic [1:0] cm, input int cv);
    if (cm == timer8_pkg::COM_TOGGLE) return 256;
    if (cm == timer8_pkg::COM_CLEAR) return 2 * (cv + 1);
    return 512 - 2 * (cv + 1);
  endfunction : exp_high

  initial begin
    repeat (40000) @(posedge clk_i);
    mismatches++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    end_sim();
  end

  initial begin
    void'($urandom(66839));
    c   = $urandom_range(254, 1);
    c2  = $urandom_range(30, 1);
    p   = $urandom_range(1, 0);
    tcv = '{c, c, 255, 255, 0, c};
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(timer8_pkg::PIN_OFS, 8'h00);
    check_val(oe_n, 1'b1);
    rd_chk(timer8_pkg::COUNT_OFS, 8'h00);
    rd_chk(timer8_pkg::FLAGS_OFS, 8'h00);
    wr(timer8_pkg::PIN_OFS, pinw(1'b0));
    for (int m = 0; m < 4; m++) begin
      wr(timer8_pkg::CTRL_OFS, ctrl(m[1:0], 2'h0, 1'b0));
      repeat (2) @(posedge clk_i);
      check_val(pad, p[0]);
      // no tick and no force, so the waveform bit is still its reset zero
      wr(timer8_pkg::CTRL_OFS, ctrl(m[1:0], 2'h2, 1'b0));
      repeat (2) @(posedge clk_i);
      check_val(pad, 1'b0);
    end
    check_val(oe_n, 1'b0);
    wr(timer8_pkg::CTRL_OFS, ctrl(2'h0, 2'h1, 1'b0));
    wr(timer8_pkg::COMPARE_OFS, 8'hfe);
    wr(timer8_pkg::COUNT_OFS, 8'hfd);
    tick_n(3);
    rd_chk(timer8_pkg::COUNT_OFS, 8'h00);
    rd_chk(timer8_pkg::FLAGS_OFS, 8'h03);
    rd_chk(timer8_pkg::PIN_OFS, pinw(1'b1));
    check_val(pad, 1'b1);
    wr(timer8_pkg::FLAGS_OFS, 8'h03);
    wr(timer8_pkg::CTRL_OFS, ctrl(2'h0, 2'h0, 1'b0));
    wr(timer8_pkg::COUNT_OFS, 8'hfd);
    tick_n(2);
    rd_chk(timer8_pkg::PIN_OFS, pinw(1'b1));
    rd_chk(timer8_pkg::FLAGS_OFS, 8'h02);
    wr(timer8_pkg::FLAGS_OFS, 8'h03);
    wr(timer8_pkg::COUNT_OFS, 8'h40);
    wr(timer8_pkg::CTRL_OFS, ctrl(2'h0, 2'h2, 1'b1));
    rd_chk(timer8_pkg::PIN_OFS, pinw(1'b0));
    rd_chk(timer8_pkg::FLAGS_OFS, 8'h00);
    rd_chk(timer8_pkg::COUNT_OFS, 8'h40);
    // a write without byte lane zero must leave the counter alone
    lanes = 4'he;
    wr(timer8_pkg::COUNT_OFS, 8'h55);
    lanes = 4'hf;
    rd_chk(timer8_pkg::COUNT_OFS, 8'h40);
    wr(timer8_pkg::CTRL_OFS, ctrl(2'h0, 2'h1, 1'b1));
    rd_chk(timer8_pkg::PIN_OFS, pinw(1'b1));
    wr(timer8_pkg::CTRL_OFS, ctrl(2'h2, 2'h2, 1'b1));
    wr(timer8_pkg::CTRL_OFS, ctrl(2'h2, 2'h3, 1'b0));
    rd_chk(timer8_pkg::PIN_OFS, pinw(1'b0));
    wr(timer8_pkg::COMPARE_OFS, 8'(c2));
    wr(timer8_pkg::COUNT_OFS, 8'h00);
    tick_n(c2 + 1);
    rd_chk(timer8_pkg::PIN_OFS, pinw(1'b1));
    rd_chk(timer8_pkg::COUNT_OFS, 8'h00);
    rd_chk(timer8_pkg::FLAGS_OFS, 8'h02);
    wr(timer8_pkg::FLAGS_OFS, 8'h03);
    wr(timer8_pkg::CTRL_OFS, ctrl(2'h2, 2'h1, 1'b0));
    tick_n(c2 + 1);
    rd_chk(timer8_pkg::PIN_OFS, pinw(1'b0));
    wr(timer8_pkg::FLAGS_OFS, 8'h03);
    wr(timer8_pkg::COUNT_OFS, 8'(c2));
    tick_n(1);
    rd_chk(timer8_pkg::COUNT_OFS, 8'(c2 + 1));
    rd_chk(timer8_pkg::FLAGS_OFS, 8'h00);
    wr(timer8_pkg::COUNT_OFS, 8'h10);
    wr(timer8_pkg::COMPARE_OFS, 8'h05);
    tick_n(240);
    rd_chk(timer8_pkg::COUNT_OFS, 8'h00);
    rd_chk(timer8_pkg::FLAGS_OFS, 8'h01);
    tick_n(6);
    rd_chk(timer8_pkg::FLAGS_OFS, 8'h03);
    for (int i = 0; i < 6; i++) begin
      wr(timer8_pkg::FLAGS_OFS, 8'h03);
      wr(timer8_pkg::COMPARE_OFS, 8'(tcv[i]));
      wr(timer8_pkg::CTRL_OFS, ctrl(2'h3, tcom[i], 1'b0));
      tick <= 1'b1;
      repeat (300) @(posedge clk_i);
      hi = 0;
      repeat (512) begin
        @(posedge clk_i);
        if (pad === 1'b1) hi++;
      end
      tick <= 1'b0;
      check_num(hi, exp_high(tcom[i], tcv[i]));
      rd_chk(timer8_pkg::FLAGS_OFS, 8'h03);
    end
    wr(timer8_pkg::CTRL_OFS, ctrl(2'h3, 2'h2, 1'b0));
    wr(timer8_pkg::COMPARE_OFS, 8'h80);
    wr(timer8_pkg::COUNT_OFS, 8'hfe);
    tick_n(2);
    rd_chk(timer8_pkg::COUNT_OFS, 8'h00);
    wr(timer8_pkg::COMPARE_OFS, 8'h10);
    rd_chk(timer8_pkg::COMPARE_OFS, 8'h10);
    tick_n(32);
    rd_chk(timer8_pkg::PIN_OFS, pinw(1'b1));
    tick_n(256);
    rd_chk(timer8_pkg::PIN_OFS, pinw(1'b0));
    end_sim();
  end
endmodule : tb_timer8_compare_waveform_unit
